/* pdbd_pkg.sv */
// shared constants and types for the pulse descriptor body decoder
package pdbd_pkg;
    // section sizes in bytes, frame and payload widths in bits
    localparam int unsigned BODY_BYTES = 8;
    localparam int unsigned PARAM_BYTES = 4;
    localparam int unsigned PAY_BYTES_BASIC = 17;
    localparam int unsigned PAY_BYTES_EXPERT = 12;
    localparam int unsigned MAX_BYTES = 29;
    localparam int unsigned FRAME_W = 232;
    localparam int unsigned PAY_W = 136;
    // byte counter reset value
    localparam logic [4:0] CNT_RST = 5'h00;
    // field widths
    localparam int unsigned FREQ_W = 32;
    localparam int unsigned ATTEN_W = 16;
    localparam int unsigned PHASE_W = 16;
    localparam int unsigned EDGE_W = 3;
    localparam int unsigned RAMP_W = 22;
    localparam int unsigned RAMP_SAMP_W = 25;
    localparam int unsigned INDEX_W = 24;
    localparam int unsigned MOD_W = 4;
    localparam int unsigned WIDTH_W = 44;
    localparam int unsigned CHIRP_W_W = 25;
    localparam int unsigned STEP_W = 64;
    localparam int unsigned TOTAL_W = 46;
    // ramp scale shift for the x8 setting
    localparam int unsigned RAMP_X8_SHIFT = 3;
    // parameter block selector codes
    localparam logic [1:0] PSEL_NONE = 2'h0;
    localparam logic [1:0] PSEL_EDGE = 2'h1;
    // modulation codes handled here
    localparam logic [3:0] MOD_RECT = 4'h0;
    localparam logic [3:0] MOD_CHIRP = 4'h1;
    // edge shape codes
    localparam logic [2:0] EDGE_LINEAR = 3'h0;
    localparam logic [2:0] EDGE_COSINE = 3'h1;
    // receiver states
    typedef enum logic [0:0] {ST_RECV, ST_EMIT} pdbd_state_e;
endpackage

/* pdbd_if.sv */
// byte link between descriptor source and decoder
`timescale 1ns/1ps
interface pdbd_if (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn
);
    logic valid; // byte offered
    logic ready; // byte accepted when both high
    logic [7:0] data; // byte, most significant first
    logic first; // marks the first body byte of a word
    logic expert; // expert format word
    logic wave_src; // waveform_source_flag
    logic [1:0] param_select; // parameter block selector
    logic ext_present; // ext_block_present flag

    modport dev (
        input sys_clk, rstn, valid, data, first, expert, wave_src,
        input param_select, ext_present,
        output ready
    );
    modport src (
        input sys_clk, rstn, ready,
        output valid, data, first, expert, wave_src, param_select,
        output ext_present
    );
endinterface

/* pdbd_device.sv */
// device end: gathers body, params and payload bytes and decodes them
// Functional notes
// - freq_shift: signed 32-bit RF frequency offset
// - attenuation_code: unsigned 16-bit level reduction
// - phase_shift: 16-bit phase over full circle
// - expert 4-byte params absent when extension present
// - unused params block filled with zeros
// - edge shaping only for real-time pulses
// - edge_shape 0 linear, 1 cosine
// - ramp_scale 0 gives x1, 1 gives x8
// - ramp added to pulse width, not inside
// - playback takes 24-bit stored_waveform_index first
// - playback payload 136/96 bits, rest reserved
// - real-time payload opens with modulation_type
// - rectangular: 44-bit pulse_width then reserved bits
// - chirp_step signed 64-bit per-sample increment
// - chirp step spans edges when shaping active
// - param_select: 0 none, 1 edge, others reserved
// - ext_block_present marks extension block use
`timescale 1ns/1ps
module pdbd_device import pdbd_pkg::*; (
    // link to the descriptor source
    pdbd_if.dev lnk,
    // decoded body
    output logic [FREQ_W-1:0] freq_shift,
    output logic [ATTEN_W-1:0] attenuation_code,
    output logic [PHASE_W-1:0] phase_shift,
    // decoded edge shaping
    output logic shaping_en,
    output logic [EDGE_W-1:0] edge_shape,
    output logic ramp_scale,
    output logic [RAMP_W-1:0] ramp_duration,
    output logic [RAMP_SAMP_W-1:0] ramp_samples,
    // decoded payload
    output logic playback,
    output logic [INDEX_W-1:0] stored_waveform_index,
    output logic [MOD_W-1:0] modulation_type,
    output logic [WIDTH_W-1:0] pulse_width,
    output logic [STEP_W-1:0] chirp_step,
    output logic [TOTAL_W-1:0] total_samples,
    // status
    output logic desc_valid,
    output logic param_reserved,
    output logic shaping_refused
);
    pdbd_state_e state_reg, state_next; // receive or present
    logic [4:0] cnt_reg, cnt_next; // bytes taken so far
    logic [FRAME_W-1:0] sr_reg, sr_next; // gathered bytes, last at bit 0
    logic exp_reg, exp_next; // header copies for this word
    logic src_reg, src_next;
    logic [1:0] psel_reg, psel_next;
    logic ext_reg, ext_next;
    logic hdr_exp, hdr_ext; // header view for length count
    logic [1:0] hdr_psel;
    logic [4:0] word_len; // bytes in the current word
    logic take; // byte handshake
    logic has_params; // params block present
    logic [PAY_W-1:0] pay; // payload left-justified
    logic [31:0] prm; // params block
    logic [63:0] body; // body section
    logic shp; // edge shaping in force
    logic [RAMP_SAMP_W-1:0] rs; // ramp in samples
    logic [WIDTH_W-1:0] pw; // decoded pulse width
    logic [STEP_W-1:0] stp; // decoded chirp step
    // registered outputs
    logic [FREQ_W-1:0] freq_next;
    logic [ATTEN_W-1:0] att_next;
    logic [PHASE_W-1:0] ph_next;
    logic shp_next, scl_next, pb_next, pres_next, pref_next, dv_next;
    logic [EDGE_W-1:0] edge_next;
    logic [RAMP_W-1:0] dur_next;
    logic [RAMP_SAMP_W-1:0] rs_next;
    logic [INDEX_W-1:0] idx_next;
    logic [MOD_W-1:0] mod_next;
    logic [WIDTH_W-1:0] pw_next;
    logic [STEP_W-1:0] stp_next;
    logic [TOTAL_W-1:0] tot_next;

    // stall the source only while a finished word is presented
    assign lnk.ready = (state_reg == ST_RECV);
    assign take = lnk.valid && lnk.ready;

    // header is live on the first byte, latched afterwards
    always_comb begin
        if (lnk.first || cnt_reg == CNT_RST) begin
            hdr_exp = lnk.expert;
            hdr_psel = lnk.param_select;
            hdr_ext = lnk.ext_present;
        end else begin
            hdr_exp = exp_reg;
            hdr_psel = psel_reg;
            hdr_ext = ext_reg;
        end
        // params ride only in expert words without extension
        word_len = hdr_exp ? 5'(BODY_BYTES + PAY_BYTES_EXPERT)
                           : 5'(BODY_BYTES + PAY_BYTES_BASIC);
        if (hdr_exp && !hdr_ext) begin
            word_len = word_len + 5'(PARAM_BYTES);
        end
    end

    // receive sequencing
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sr_next = sr_reg;
        exp_next = exp_reg;
        src_next = src_reg;
        psel_next = psel_reg;
        ext_next = ext_reg;
        case (state_reg)
            ST_RECV: begin
                if (take) begin
                    sr_next = {sr_reg[FRAME_W-9:0], lnk.data};
                    // a first marker restarts the count
                    if (lnk.first || cnt_reg == CNT_RST) begin
                        exp_next = lnk.expert;
                        src_next = lnk.wave_src;
                        psel_next = lnk.param_select;
                        ext_next = lnk.ext_present;
                        cnt_next = 5'h01;
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                    if (cnt_next == word_len) begin
                        state_next = ST_EMIT;
                        cnt_next = CNT_RST;
                    end
                end
            end
            ST_EMIT: begin
                state_next = ST_RECV;
            end
            default: begin
                state_next = ST_RECV;
                cnt_next = CNT_RST;
            end
        endcase
    end

    // receive registers
    always_ff @(posedge lnk.sys_clk or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
            state_reg <= ST_RECV;
            cnt_reg <= CNT_RST;
            sr_reg <= '0;
            exp_reg <= 1'b0;
            src_reg <= 1'b0;
            psel_reg <= PSEL_NONE;
            ext_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sr_reg <= sr_next;
            exp_reg <= exp_next;
            src_reg <= src_next;
            psel_reg <= psel_next;
            ext_reg <= ext_next;
        end
    end

    // split the gathered bytes into sections
    always_comb begin
        has_params = exp_reg && !ext_reg;
        if (exp_reg) begin
            pay = {sr_reg[95:0], 40'h0000000000};
        end else begin
            pay = sr_reg[135:0];
        end
        // params sit just above the payload when present
        prm = has_params ? sr_reg[127:96] : 32'h00000000;
        if (!exp_reg) begin
            body = sr_reg[199:136];
        end else if (has_params) begin
            body = sr_reg[191:128];
        end else begin
            body = sr_reg[159:96];
        end
        // edge data honoured only for real-time words
        shp = has_params && psel_reg == PSEL_EDGE && !src_reg;
        // x8 widens the ramp by three bit places
        rs = prm[28] ? {prm[21:0], 3'h0} : {3'h0, prm[21:0]};
        pw = '0;
        stp = '0;
        if (!src_reg && pay[135:132] == MOD_RECT) begin
            pw = pay[131:88];
        end else if (!src_reg && pay[135:132] == MOD_CHIRP) begin
            // reserved run is 19 bits basic, 3 bits expert
            if (exp_reg) begin
                pw = {19'h00000, pay[128:104]};
                stp = pay[103:40];
            end else begin
                pw = {19'h00000, pay[112:88]};
                stp = pay[87:24];
            end
        end
    end

    // present decoded fields; reserved bits never reach them
    always_comb begin
        freq_next = freq_shift;
        att_next = attenuation_code;
        ph_next = phase_shift;
        shp_next = shaping_en;
        edge_next = edge_shape;
        scl_next = ramp_scale;
        dur_next = ramp_duration;
        rs_next = ramp_samples;
        pb_next = playback;
        idx_next = stored_waveform_index;
        mod_next = modulation_type;
        pw_next = pulse_width;
        stp_next = chirp_step;
        tot_next = total_samples;
        pres_next = param_reserved;
        pref_next = shaping_refused;
        dv_next = 1'b0;
        if (state_reg == ST_EMIT) begin
            dv_next = 1'b1;
            freq_next = body[63:32];
            att_next = body[31:16];
            ph_next = body[15:0];
            shp_next = shp;
            // shape, scale and ramp read only with shaping on
            edge_next = shp ? prm[31:29] : EDGE_LINEAR;
            scl_next = shp ? prm[28] : 1'b0;
            dur_next = shp ? prm[21:0] : '0;
            rs_next = shp ? rs : '0;
            pb_next = src_reg;
            idx_next = src_reg ? pay[135:112] : '0;
            mod_next = src_reg ? MOD_RECT : pay[135:132];
            pw_next = pw;
            stp_next = stp;
            // both edges extend the on time
            tot_next = {2'h0, pw} + (shp ? {20'h00000, rs, 1'b0}
                                         : 46'h0);
            pres_next = has_params && psel_reg[1];
            pref_next = has_params && psel_reg == PSEL_EDGE
                        && src_reg;
        end
    end

    // output registers
    always_ff @(posedge lnk.sys_clk or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
            freq_shift <= '0;
            attenuation_code <= '0;
            phase_shift <= '0;
            shaping_en <= 1'b0;
            edge_shape <= EDGE_LINEAR;
            ramp_scale <= 1'b0;
            ramp_duration <= '0;
            ramp_samples <= '0;
            playback <= 1'b0;
            stored_waveform_index <= '0;
            modulation_type <= MOD_RECT;
            pulse_width <= '0;
            chirp_step <= '0;
            total_samples <= '0;
            param_reserved <= 1'b0;
            shaping_refused <= 1'b0;
            desc_valid <= 1'b0;
        end else begin
            freq_shift <= freq_next;
            attenuation_code <= att_next;
            phase_shift <= ph_next;
            shaping_en <= shp_next;
            edge_shape <= edge_next;
            ramp_scale <= scl_next;
            ramp_duration <= dur_next;
            ramp_samples <= rs_next;
            playback <= pb_next;
            stored_waveform_index <= idx_next;
            modulation_type <= mod_next;
            pulse_width <= pw_next;
            chirp_step <= stp_next;
            total_samples <= tot_next;
            param_reserved <= pres_next;
            shaping_refused <= pref_next;
            desc_valid <= dv_next;
        end
    end
endmodule // pdbd_device

/* pdbd_source.sv */
// source end: packs a descriptor body, params and payload into bytes
`timescale 1ns/1ps
module pdbd_source import pdbd_pkg::*; (
    // link to the decoder
    pdbd_if.src lnk,
    // word request
    input wire logic start,
    input wire logic expert,
    input wire logic wave_src,
    input wire logic [1:0] param_select,
    input wire logic ext_present,
    // field values
    input wire logic [FREQ_W-1:0] freq_shift,
    input wire logic [ATTEN_W-1:0] attenuation_code,
    input wire logic [PHASE_W-1:0] phase_shift,
    input wire logic [EDGE_W-1:0] edge_shape,
    input wire logic ramp_scale,
    input wire logic [RAMP_W-1:0] ramp_duration,
    input wire logic [INDEX_W-1:0] stored_waveform_index,
    input wire logic [MOD_W-1:0] modulation_type,
    input wire logic [WIDTH_W-1:0] pulse_width,
    input wire logic [STEP_W-1:0] chirp_step,
    // status
    output logic busy,
    output logic [TOTAL_W-1:0] chirp_span
);
    logic [FRAME_W-1:0] sr_reg, sr_next; // bytes still to send
    logic [4:0] left_reg, left_next; // bytes still to send
    logic first_reg, first_next;
    logic exp_reg, exp_next, src_reg, src_next, ext_reg, ext_next;
    logic [1:0] psel_reg, psel_next;
    logic [1:0] psel_eff; // selector after policing
    logic with_prm; // params block travels
    logic [63:0] body;
    logic [31:0] prm;
    logic [PAY_W-1:0] pay;
    logic [RAMP_SAMP_W-1:0] rs;

    // edge shaping is dropped for stored playback
    assign psel_eff = wave_src ? PSEL_NONE : param_select;
    assign with_prm = expert && !ext_present;
    assign rs = ramp_scale ? {ramp_duration, 3'h0}
                           : {3'h0, ramp_duration};

    // span the user needs to compute the chirp step over
    always_comb begin
        chirp_span = {2'h0, pulse_width};
        if (with_prm && psel_eff == PSEL_EDGE) begin
            chirp_span = {2'h0, pulse_width} + {20'h00000, rs, 1'b0};
        end
    end

    // assemble sections, reserved bits zero
    always_comb begin
        body = {freq_shift, attenuation_code, phase_shift};
        prm = 32'h00000000;
        if (psel_eff == PSEL_EDGE) begin
            prm = {edge_shape, ramp_scale, 6'h00, ramp_duration};
        end
        pay = '0;
        if (wave_src) begin
            pay[135:112] = stored_waveform_index;
        end else if (modulation_type == MOD_CHIRP) begin
            pay[135:132] = MOD_CHIRP;
            if (expert) begin
                pay[128:104] = pulse_width[24:0];
                pay[103:40] = chirp_step;
            end else begin
                pay[112:88] = pulse_width[24:0];
                pay[87:24] = chirp_step;
            end
        end else begin
            pay[135:132] = modulation_type;
            pay[131:88] = pulse_width;
        end
    end

    // load on start when idle, shift on each accepted byte
    always_comb begin
        sr_next = sr_reg;
        left_next = left_reg;
        first_next = first_reg;
        exp_next = exp_reg;
        src_next = src_reg;
        psel_next = psel_reg;
        ext_next = ext_reg;
        if (left_reg != CNT_RST) begin
            if (lnk.ready) begin
                sr_next = {sr_reg[FRAME_W-9:0], 8'h00};
                left_next = left_reg - 5'h01;
                first_next = 1'b0;
            end
        end else if (start) begin
            exp_next = expert;
            src_next = wave_src;
            psel_next = with_prm ? psel_eff : PSEL_NONE;
            ext_next = ext_present;
            first_next = 1'b1;
            if (with_prm) begin
                sr_next = {body, prm, pay};
            end else begin
                sr_next = {body, pay, 32'h00000000};
            end
            left_next = 5'(BODY_BYTES)
                + (expert ? 5'(PAY_BYTES_EXPERT) : 5'(PAY_BYTES_BASIC))
                + (with_prm ? 5'(PARAM_BYTES) : 5'h00);
        end
    end

    // source registers
    always_ff @(posedge lnk.sys_clk or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
            sr_reg <= '0;
            left_reg <= CNT_RST;
            first_reg <= 1'b0;
            exp_reg <= 1'b0;
            src_reg <= 1'b0;
            psel_reg <= PSEL_NONE;
            ext_reg <= 1'b0;
        end else begin
            sr_reg <= sr_next;
            left_reg <= left_next;
            first_reg <= first_next;
            exp_reg <= exp_next;
            src_reg <= src_next;
            psel_reg <= psel_next;
            ext_reg <= ext_next;
        end
    end

    // link drive; header held for the whole word
    assign lnk.valid = (left_reg != CNT_RST);
    assign lnk.data = sr_reg[FRAME_W-1:FRAME_W-8];
    assign lnk.first = first_reg;
    assign lnk.expert = exp_reg;
    assign lnk.wave_src = src_reg;
    assign lnk.param_select = psel_reg;
    assign lnk.ext_present = ext_reg;
    assign busy = (left_reg != CNT_RST);
endmodule // pdbd_source

/* pdbd_asserts.sv */
// link protocol checks for the descriptor byte stream
`timescale 1ns/1ps
module pdbd_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link signals
    input wire logic valid,
    input wire logic ready,
    input wire logic [7:0] data,
    input wire logic first,
    input wire logic expert,
    input wire logic wave_src,
    input wire logic [1:0] param_select,
    input wire logic ext_present
);
    logic [4:0] cnt_reg; // bytes taken in this word
    logic [4:0] cnt_next;
    logic [4:0] len; // word length in bytes
    logic [4:0] pay; // first payload byte
    logic take; // byte handshake
    logic last; // final byte of a word taken
    // length follows format, so a lost params block shows as a late refusal
    always_comb begin
        len = !expert ? 5'h19 : (ext_present ? 5'h14 : 5'h18);
        pay = (expert && !ext_present) ? 5'h0C : 5'h08;
        take = valid && ready;
        last = take && (cnt_reg == len - 5'h01);
        cnt_next = cnt_reg;
        if (last) begin
            cnt_next = 5'h00; // wrap for the next word
        end else if (take) begin
            cnt_next = cnt_reg + 5'h01;
        end
    end
    // count register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_refuse; last |=> !ready ##1 ready; endproperty
    property p_early; !ready |-> $past(last); endproperty
    property p_quiet; last |=> !valid; endproperty
    property p_first; valid |-> first == (cnt_reg == 5'h00); endproperty
    property p_side;
        valid && cnt_reg != 5'h00
            |-> $stable({expert, wave_src, param_select, ext_present});
    endproperty
    property p_psel; valid && wave_src |-> param_select == 2'h0; endproperty
    property p_fill;
        take && pay == 5'h0C && param_select == 2'h0 && cnt_reg >= 5'h08
            && cnt_reg < 5'h0C |-> data == 8'h00;
    endproperty
    property p_rsvd;
        take && wave_src && cnt_reg >= pay + 5'h03 |-> data == 8'h00;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("ready not low for exactly one cycle");
    a_early: assert property (p_early)
        else $error("ready low without a finished word");
    a_quiet: assert property (p_quiet)
        else $error("byte offered past word end");
    a_first: assert property (p_first)
        else $error("first marker misplaced");
    a_side: assert property (p_side)
        else $error("header sideband moved mid word");
    a_psel: assert property (p_psel)
        else $error("shaping selected for playback");
    a_fill: assert property (p_fill)
        else $error("unused params block not zero");
    a_rsvd: assert property (p_rsvd)
        else $error("playback reserved byte not zero");
    c_basic: cover property (last && !expert);
    c_ext: cover property (last && expert && ext_present);
    c_shape: cover property (take && first && pay == 5'h0C
        && param_select == 2'h1);
endmodule // pdbd_asserts

/* test_pulse_descriptor_body_decoder.sv */
// bench: source and decoder joined over the byte link
`timescale 1ns/1ps
module test_pulse_descriptor_body_decoder import pdbd_pkg::*;;
    // expected decode of one word
    typedef struct packed {
        logic [63:0] body; // freq, level, phase
        logic sh; // shaping expected
        logic [26:0] shp; // edge, scale, duration
        logic [24:0] rs; // ramp samples
        logic [28:0] src; // playback, index, modulation
        logic [43:0] pw;
        logic [63:0] st;
        logic [45:0] tot;
        logic [1:0] flg; // reserved select, refused
    } pdbd_exp_s;
    logic sys_clk, rstn;
    // source requests
    logic start, expert, wave_src, ext_present, ramp_scale, busy;
    logic [1:0] param_select;
    logic [31:0] freq_shift;
    logic [15:0] attenuation_code, phase_shift;
    logic [2:0] edge_shape;
    logic [21:0] ramp_duration;
    logic [23:0] stored_waveform_index;
    logic [3:0] modulation_type;
    logic [43:0] pulse_width;
    logic [63:0] chirp_step;
    logic [45:0] chirp_span;
    // decoder outputs
    logic [31:0] d_fr;
    logic [15:0] d_at, d_ph;
    logic d_shen, d_sc, d_pb, d_valid, d_rsv, d_ref;
    logic [2:0] d_eg;
    logic [21:0] d_du;
    logic [24:0] d_rs;
    logic [23:0] d_ix;
    logic [3:0] d_md;
    logic [43:0] d_pw;
    logic [63:0] d_step;
    logic [45:0] d_tot;
    pdbd_exp_s exp_q[$]; // notes in send order
    pdbd_exp_s got;
    int fail_count, n_checks;
    pdbd_if pdbd_if_inst (.sys_clk(sys_clk), .rstn(rstn));
    pdbd_source pdbd_source_inst (
        .lnk(pdbd_if_inst.src), .start(start), .expert(expert),
        .wave_src(wave_src), .param_select(param_select),
        .ext_present(ext_present), .freq_shift(freq_shift),
        .attenuation_code(attenuation_code), .phase_shift(phase_shift),
        .edge_shape(edge_shape), .ramp_scale(ramp_scale),
        .ramp_duration(ramp_duration),
        .stored_waveform_index(stored_waveform_index),
        .modulation_type(modulation_type), .pulse_width(pulse_width),
        .chirp_step(chirp_step), .busy(busy), .chirp_span(chirp_span)
    );
    pdbd_device pdbd_device_inst (
        .lnk(pdbd_if_inst.dev), .freq_shift(d_fr), .attenuation_code(d_at),
        .phase_shift(d_ph), .shaping_en(d_shen), .edge_shape(d_eg),
        .ramp_scale(d_sc), .ramp_duration(d_du), .ramp_samples(d_rs),
        .playback(d_pb), .stored_waveform_index(d_ix),
        .modulation_type(d_md), .pulse_width(d_pw), .chirp_step(d_step),
        .total_samples(d_tot), .desc_valid(d_valid),
        .param_reserved(d_rsv), .shaping_refused(d_ref)
    );
    pdbd_asserts pdbd_asserts_inst (
        .sys_clk(sys_clk), .rstn(rstn), .valid(pdbd_if_inst.valid),
        .ready(pdbd_if_inst.ready), .data(pdbd_if_inst.data),
        .first(pdbd_if_inst.first), .expert(pdbd_if_inst.expert),
        .wave_src(pdbd_if_inst.wave_src),
        .param_select(pdbd_if_inst.param_select),
        .ext_present(pdbd_if_inst.ext_present)
    );
    // one comparison, reported at once
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] s);
        n_checks++;
        if (e !== s) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // send one word from a falling edge; abort cuts it with a reset
    task automatic send(input int fmt, input logic ws, input logic [3:0] m,
                        input logic [1:0] p, input bit abort);
        pdbd_exp_s e;
        int k;
        expert = fmt != 0;
        ext_present = fmt == 2;
        {wave_src, param_select, modulation_type} = {ws, p, m};
        freq_shift = $urandom();
        {attenuation_code, phase_shift} = $urandom();
        edge_shape = 3'($urandom() % 2); // linear or cosine
        ramp_scale = 1'($urandom());
        ramp_duration = 22'($urandom());
        stored_waveform_index = 24'($urandom());
        pulse_width = {12'($urandom()), $urandom()};
        if (m == MOD_CHIRP) pulse_width[43:25] = '0; // 25-bit chirp width
        chirp_step = {$urandom(), $urandom()};
        e.body = {freq_shift, attenuation_code, phase_shift};
        e.sh = expert && !ext_present && !ws && p == PSEL_EDGE;
        e.shp = {edge_shape, ramp_scale, ramp_duration};
        e.rs = ramp_scale ? {ramp_duration, 3'h0} : {3'h0, ramp_duration};
        e.src = {ws, ws ? stored_waveform_index : 24'h0, ws ? 4'h0 : m};
        e.pw = m > MOD_CHIRP ? 44'h0 : pulse_width;
        e.st = m == MOD_CHIRP ? chirp_step : 64'h0;
        e.tot = {2'h0, e.pw} + (e.sh ? {20'h0, e.rs, 1'b0} : 46'h0);
        e.flg = {expert && !ext_present && !ws && p[1], 1'b0};
        #1;
        if (!ws && m == MOD_CHIRP) chk("span", e.tot, chirp_span);
        start = 1'b1;
        exp_q.push_back(e);
        @(negedge sys_clk);
        start = 1'b0;
        if (abort) begin
            repeat (5) @(negedge sys_clk);
            rstn = 1'b0;
            void'(exp_q.pop_back());
            @(negedge sys_clk);
            chk("reset valid", 64'h0, d_valid);
            chk("reset body", 64'h0, {d_fr, d_at, d_ph});
            rstn = 1'b1;
        end
        // next start may land the cycle busy falls
        for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge sys_clk);
        if (k == 40) begin
            fail_count++;
            $display("[FAIL] busy expected 0 seen 1");
            summarize();
        end
    endtask
    // settled outputs are sampled on the falling edge
    always @(negedge sys_clk) begin
        if (d_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("stray word", 64'h0, 64'h1);
            end else begin
                got = exp_q.pop_front();
                chk("body", got.body, {d_fr, d_at, d_ph});
                chk("shaping", got.sh, d_shen);
                if (got.sh) begin
                    chk("edge", got.shp, {d_eg, d_sc, d_du});
                    chk("ramp", got.rs, d_rs);
                end
                chk("source", got.src, {d_pb, d_ix, d_md});
                if (!got.src[28]) begin
                    chk("width", got.pw, d_pw);
                    chk("step", got.st, d_step);
                    chk("total", got.tot, d_tot);
                end
                chk("flags", got.flg, {d_rsv, d_ref});
            end
        end
    end
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // main sequence
    initial begin
        {fail_count, n_checks, rstn, start} = '0;
        {expert, wave_src, ext_present, ramp_scale, param_select} = '0;
        {freq_shift, attenuation_code, phase_shift, edge_shape} = '0;
        {ramp_duration, stored_waveform_index, modulation_type} = '0;
        {pulse_width, chirp_step} = '0;
        void'($urandom(32'h7EBB));
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        // every format, source and selector, modulations 0 to 2, back to back
        for (int f = 0; f < 3; f++) begin
            for (int w = 0; w < 2; w++) begin
                for (int m = 0; m < 3; m++) begin
                    for (int p = 0; p < 4; p++) begin
                        send(f, w[0], 4'(m), 2'(p), 1'b0);
                    end
                end
            end
        end
        send(1, 1'b0, MOD_CHIRP, PSEL_EDGE, 1'b1);
        send(1, 1'b0, MOD_CHIRP, PSEL_EDGE, 1'b0);
        for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(negedge sys_clk);
        chk("pending", 64'h0, exp_q.size());
        summarize();
    end
endmodule // test_pulse_descriptor_body_decoder
